/* src/scri_pkg.sv */
// Purpose: constants and types for the script call, return and interrupt unit
// Assumes: one 200 MHz clock, async active-low reset
// Notes: instruction fields follow a two-word transfer-control layout
// What this block does
// - true call saves next address, jumps
// - single return slot, overwritten by calls
// - true return reloads pointer from slot
// - wait bit selects wait-for-phase form
// - transfer taken when result equals true bit
// - phase test compares held bus phase
// - data test compares first byte received
// - mask bits set are excluded from compare
// - phase and data combine, both must match
// - inverted forms negate every test kind
// - carry test stands alone
// - target role tests initiator ATN
// - relative option adds signed 24-bit displacement
// - true interrupt halts, raises irq when unmasked, stores vector
package scri_pkg;
	// Opcode field, word 0 bits 29:27
	localparam int OP_HI = 29;
	localparam int OP_LO = 27;
	localparam logic [2:0] OP_CALL = 3'h1;
	localparam logic [2:0] OP_RET = 3'h2;
	localparam logic [2:0] OP_INT = 3'h3;
	// Condition bits of word 0
	localparam int BIT_REL = 23;
	localparam int BIT_CARRY = 21;
	localparam int BIT_TRUE = 19;
	localparam int BIT_DATA = 18;
	localparam int BIT_PHASE = 17;
	localparam int BIT_WAIT = 16;
	localparam int PH_HI = 26;
	localparam int PH_LO = 24;
	localparam int MASK_HI = 15;
	localparam int MASK_LO = 8;
	localparam int DATA_HI = 7;
	localparam int DATA_LO = 0;
	localparam int DISP_HI = 23;
	localparam int DISP_W = 24;
	localparam logic [31:0] INSN_BYTES = 32'h0000_0008;
	localparam logic [31:0] ZERO32 = 32'h0000_0000;
	// APB map
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_STAT = 8'h04;
	localparam logic [7:0] A_MASK = 8'h08;
	localparam logic [7:0] A_VEC = 8'h0C;
	localparam logic [7:0] A_RET = 8'h10;
	localparam logic [7:0] A_PC = 8'h14;
	// Status and control layout
	localparam int ST_W = 3;
	localparam int EV_INT = 0;
	localparam int EV_CALL = 1;
	localparam int EV_RET = 2;
	localparam int CT_TARGET = 0;
	localparam int CT_RESUME = 1;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_WAITPH = 2'b01,
		ST_HALT = 2'b10
	} scri_state_e;
endpackage

/* src/scri_cond_if.sv */
// Purpose: carries condition inputs and result between the unit's modules
// Assumes: single clock
// Notes: purely combinational signals
`timescale 1ns/100ps
`default_nettype none
interface scri_cond_if;
	logic [31:0] insnWord;
	logic [2:0] busPhase;
	logic [7:0] firstByteReceived;
	logic carryFlag;
	logic atnSeen;
	logic targetRole;
	logic condTrue;
	modport eval (input insnWord, busPhase, firstByteReceived, carryFlag, atnSeen,
		targetRole, output condTrue);
	modport user (output insnWord, busPhase, firstByteReceived, carryFlag, atnSeen,
		targetRole, input condTrue);
endinterface
`default_nettype wire

/* src/scri_cond_eval.sv */
// Purpose: evaluates a transfer-control condition
// Assumes: inputs stable while the decoder evaluates
// Notes: combinational
`timescale 1ns/100ps
`default_nettype none
module scri_cond_eval (
	scri_cond_if.eval c
);
	logic phOk, dataOk, cmp, anyTest;
	logic [7:0] keep;
	always_comb begin
		keep = ~c.insnWord[scri_pkg::MASK_HI:scri_pkg::MASK_LO];
		phOk = c.insnWord[scri_pkg::PH_HI:scri_pkg::PH_LO] == c.busPhase;
		dataOk = ((c.insnWord[scri_pkg::DATA_HI:scri_pkg::DATA_LO] ^ c.firstByteReceived)
			& keep) == 8'h00;
		anyTest = c.insnWord[scri_pkg::BIT_CARRY] | c.insnWord[scri_pkg::BIT_PHASE]
			| c.insnWord[scri_pkg::BIT_DATA];
		if (c.insnWord[scri_pkg::BIT_CARRY]) begin
			cmp = c.carryFlag;
		end else begin
			cmp = 1'b1;
			if (c.insnWord[scri_pkg::BIT_PHASE]) begin
				// In target role the phase test becomes the ATN test
				cmp = c.targetRole ? c.atnSeen : phOk;
			end
			if (c.insnWord[scri_pkg::BIT_DATA]) begin
				cmp = cmp & dataOk;
			end
		end
		// Inverted form is the negation since compare equals true bit
		c.condTrue = anyTest ? (cmp == c.insnWord[scri_pkg::BIT_TRUE]) : 1'b1;
	end
endmodule
`default_nettype wire

/* src/scri_unit.sv */
// Purpose: call, return and halting interrupt execution with APB registers
// Assumes: instruction presented with insnValid, held until insnDone
// Notes: status bits clear on read; one interrupt level output
//
// The implementer's own choices: the address map and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
module scri_unit (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Instruction from fetch
	input wire logic insnValid,
	input wire logic [31:0] insnWord0,
	input wire logic [31:0] insnWord1,
	input wire logic [31:0] insnPc,
	output logic insnDone,
	// Fetch redirect
	output logic [31:0] fetchAddr,
	output logic fetchLoad,
	output logic halted,
	// Bus state
	input wire logic [2:0] busPhase,
	input wire logic phaseRequest,
	input wire logic atnIn,
	input wire logic [7:0] firstByteReceived,
	input wire logic carryFlag,
	// Interrupt
	output logic irq
);
	scri_cond_if cif ();
	scri_cond_eval u_eval (.c(cif));

	scri_pkg::scri_state_e state, next_state;
	logic [31:0] retAddr, next_retAddr;
	logic [31:0] vecReg, next_vecReg;
	logic [31:0] fetchAddr_q, next_fetchAddr;
	logic fetchLoad_q, next_fetchLoad;
	logic done_q, next_done;
	logic [scri_pkg::ST_W-1:0] stat, next_stat, maskReg, next_maskReg, ev;
	logic [1:0] ctrl, next_ctrl;
	logic [31:0] rd, next_rd;
	logic [2:0] op;
	logic [31:0] nextPc, target, disp;
	logic rdStat, apbWr, resume;

	assign cif.insnWord = insnWord0;
	assign cif.busPhase = busPhase;
	assign cif.firstByteReceived = firstByteReceived;
	assign cif.carryFlag = carryFlag;
	assign cif.atnSeen = atnIn;
	assign cif.targetRole = ctrl[scri_pkg::CT_TARGET];

	assign op = insnWord0[scri_pkg::OP_HI:scri_pkg::OP_LO];
	assign nextPc = insnPc + scri_pkg::INSN_BYTES;
	// Displacement is signed, sign extended to the pointer width
	assign disp = {{(32 - scri_pkg::DISP_W){insnWord1[scri_pkg::DISP_HI]}},
		insnWord1[scri_pkg::DISP_HI:0]};
	assign target = insnWord0[scri_pkg::BIT_REL] ? nextPc + disp : insnWord1;
	assign apbWr = psel & penable & pwrite;
	assign rdStat = psel & penable & ~pwrite & (paddr == scri_pkg::A_STAT);
	assign resume = apbWr & (paddr == scri_pkg::A_CTRL) & pwdata[scri_pkg::CT_RESUME];

	always_comb begin
		next_state = state;
		next_retAddr = retAddr;
		next_vecReg = vecReg;
		next_fetchAddr = fetchAddr_q;
		next_fetchLoad = 1'b0;
		next_done = 1'b0;
		ev = '0;
		case (state)
			scri_pkg::ST_IDLE: begin
				if (insnValid && !done_q) begin
					if (insnWord0[scri_pkg::BIT_WAIT] && !phaseRequest) begin
						next_state = scri_pkg::ST_WAITPH;
					end else begin
						next_done = 1'b1;
						if (cif.condTrue) begin
							case (op)
								scri_pkg::OP_CALL: begin
									next_retAddr = nextPc;
									next_fetchAddr = target;
									next_fetchLoad = 1'b1;
									ev[scri_pkg::EV_CALL] = 1'b1;
								end
								scri_pkg::OP_RET: begin
									next_fetchAddr = retAddr;
									next_fetchLoad = 1'b1;
									ev[scri_pkg::EV_RET] = 1'b1;
								end
								scri_pkg::OP_INT: begin
									next_vecReg = insnWord1;
									next_state = scri_pkg::ST_HALT;
									ev[scri_pkg::EV_INT] = 1'b1;
								end
								default: begin
									next_done = 1'b1;
								end
							endcase
						end
					end
				end
			end
			scri_pkg::ST_WAITPH: begin
				// Hold off evaluation until a fresh phase is requested
				if (phaseRequest) begin
					next_state = scri_pkg::ST_IDLE;
				end
			end
			scri_pkg::ST_HALT: begin
				if (resume) begin
					next_state = scri_pkg::ST_IDLE;
				end
			end
			default: begin
				next_state = scri_pkg::ST_IDLE;
			end
		endcase
	end

	always_comb begin
		next_ctrl = ctrl;
		next_maskReg = maskReg;
		if (apbWr && paddr == scri_pkg::A_CTRL) begin
			next_ctrl = {1'b0, pwdata[scri_pkg::CT_TARGET]};
		end
		if (apbWr && paddr == scri_pkg::A_MASK) begin
			next_maskReg = pwdata[scri_pkg::ST_W-1:0];
		end
		// Set wins over read-clear so no event is lost
		next_stat = (rdStat ? '0 : stat) | ev;
		case (paddr)
			scri_pkg::A_CTRL: next_rd = {30'h0, state == scri_pkg::ST_HALT,
				ctrl[scri_pkg::CT_TARGET]};
			scri_pkg::A_STAT: next_rd = {29'h0, stat};
			scri_pkg::A_MASK: next_rd = {29'h0, maskReg};
			scri_pkg::A_VEC: next_rd = vecReg;
			scri_pkg::A_RET: next_rd = retAddr;
			scri_pkg::A_PC: next_rd = fetchAddr_q;
			default: next_rd = scri_pkg::ZERO32;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= scri_pkg::ST_IDLE;
			retAddr <= '0;
			vecReg <= '0;
			fetchAddr_q <= '0;
			fetchLoad_q <= 1'b0;
			done_q <= 1'b0;
			stat <= '0;
			maskReg <= '0;
			ctrl <= '0;
			rd <= '0;
		end else begin
			state <= next_state;
			retAddr <= next_retAddr;
			vecReg <= next_vecReg;
			fetchAddr_q <= next_fetchAddr;
			fetchLoad_q <= next_fetchLoad;
			done_q <= next_done;
			stat <= next_stat;
			maskReg <= next_maskReg;
			ctrl <= next_ctrl;
			rd <= next_rd;
		end
	end

	assign prdata = rd;
	// Zero wait states; read data sampled from the setup cycle address
	assign pready = 1'b1;
	assign pslverr = 1'b0;
	assign insnDone = done_q;
	assign fetchAddr = fetchAddr_q;
	assign fetchLoad = fetchLoad_q;
	assign halted = state == scri_pkg::ST_HALT;
	assign irq = |(stat & maskReg);
endmodule
`default_nettype wire

/* sim/scri_checker.sv */
// Purpose: port checks for the unit
// Assumes: one clock, async active-low reset
// Notes: wait forms skipped where inputs may move
`timescale 1ns/100ps
`default_nettype none
module scri_checker(
	// All watched ports
	input wire logic clk, rst_n, insnValid, insnDone, fetchLoad, halted, phaseRequest, carryFlag,
	input wire logic [31:0] insnWord0, insnWord1, insnPc, fetchAddr
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	wire logic [2:0] op = insnWord0[29:27];
	property p_ld; fetchLoad |-> insnDone; endproperty
	a_ld: assert property (p_ld) else $error("load without done");
	property p_abs; fetchLoad && $past(op) == scri_pkg::OP_CALL && !$past(insnWord0[23])
		|-> fetchAddr == $past(insnWord1); endproperty
	a_abs: assert property (p_abs) else $error("bad call target");
	property p_rel; fetchLoad && $past(op) == scri_pkg::OP_CALL && $past(insnWord0[23])
		|-> fetchAddr == $past(insnPc) + 8 + {{8{$past(insnWord1[23])}}, $past(insnWord1[23:0])};
	endproperty
	a_rel: assert property (p_rel) else $error("bad relative target");
	property p_carry; insnDone && $past(op) == scri_pkg::OP_CALL && $past(insnWord0[21])
		&& !$past(insnWord0[16]) |-> fetchLoad == ($past(carryFlag) == $past(insnWord0[19]));
	endproperty
	a_carry: assert property (p_carry) else $error("bad carry test");
	property p_unc; insnDone && $past(op) != scri_pkg::OP_INT
		&& ($past(insnWord0[21:17]) & 5'h13) == 0 |-> fetchLoad; endproperty
	a_unc: assert property (p_unc) else $error("plain form not taken");
	property p_halt; $rose(halted) |-> insnDone && $past(op) == scri_pkg::OP_INT; endproperty
	a_halt: assert property (p_halt) else $error("halt without interrupt");
	property p_hold; halted && $past(halted) |-> !insnDone && !fetchLoad; endproperty
	a_hold: assert property (p_hold) else $error("ran while halted");
	property p_wait; (insnValid && insnWord0[16] && !phaseRequest)[*3] |=> !insnDone;
	endproperty
	a_wait: assert property (p_wait) else $error("no wait for phase");
endmodule
bind scri_unit scri_checker u_chk(.clk, .rst_n, .insnValid, .insnDone, .fetchLoad, .halted,
	.phaseRequest, .carryFlag, .insnWord0, .insnWord1, .insnPc, .fetchAddr);
`default_nettype wire

/* sim/scri_bus_model.sv */
// Purpose: far bus side raising a new phase request
// Assumes: armed while an instruction is presented
// Notes: lag sets prompt or slow answers
`timescale 1ns/100ps
`default_nettype none
module scri_bus_model(
	// Control and request
	input wire logic clk, rst_n, arm,
	input wire logic [2:0] lag,
	output logic phaseRequest
);
	logic [2:0] cnt;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			cnt <= 3'h0;
		else if (!arm)
			cnt <= 3'h0;
		else if (cnt != 3'h7)
			cnt <= cnt + 3'h1;
	end
	assign phaseRequest = arm && cnt >= lag;
endmodule
`default_nettype wire

/* sim/tb_script_call_return_interrupt_unit.sv */
// Purpose: random and corner tests of call, return, interrupt
// Assumes: bus inputs held while an instruction runs
// Notes: expectations come from ev()
`timescale 1ns/100ps
`default_nettype none
module tb_script_call_return_interrupt_unit;
	logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, insnValid = 0, mk = 0;
	logic carryFlag = 0, atnIn = 0, arm = 0, pready, pslverr, insnDone, fetchLoad, halted, irq;
	logic phaseRequest;
	logic [7:0] paddr = 0, firstByteReceived = 0;
	logic [7:0] fbs [3] = '{8'h80, 8'h01, 8'hFF};
	logic [2:0] busPhase = 0, lag = 0;
	logic [31:0] pwdata = 0, insnWord0 = 0, insnWord1 = 0, insnPc = 0, prdata, fetchAddr;
	logic [31:0] lf = 14471, retM = 0, r, w0, t, u;
	int n_errors = 0, n_tests = 0, cyc = 0;
	scri_unit uut(.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .insnValid, .insnWord0, .insnWord1, .insnPc, .insnDone, .fetchAddr,
		.fetchLoad, .halted, .busPhase, .phaseRequest, .atnIn, .firstByteReceived,
		.carryFlag, .irq);
	scri_bus_model bus(.clk, .rst_n, .arm, .lag, .phaseRequest);
	initial forever #2.5 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			report_and_stop();
		end
	end
	function automatic logic [31:0] nx(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// Carry alone, else phase or ATN, and masked data
	function automatic logic ev(input logic [31:0] w, input logic [2:0] ph,
		input logic [7:0] fb, input logic cy, at, ro);
		if (w[21])
			return cy;
		return (!w[17] || (ro ? at : w[26:24] == ph)) && (!w[18] || ((w[7:0] ^ fb) & ~w[15:8]) == 0);
	endfunction
	task chk(input logic [31:0] got, exp);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	task report_and_stop;
		$display("mismatches %0d checks %0d", n_errors, n_tests);
		if (n_errors == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge clk);
		penable <= 1;
		do @(posedge clk); while (pready !== 1 && n++ < 20);
		// A slave that never answers counts against the run
		if (pready !== 1)
			n_errors++;
		r = prdata;
		{psel, penable} <= 2'b00;
	endtask
	task one(input logic [31:0] w, v, pc, input logic [2:0] ph, input logic [7:0] fb,
		input logic cy, at, ro);
		logic e;
		int n;
		n = 0;
		apb(1, 8'h08, {31'h0, mk});
		apb(1, 8'h00, {31'h0, ro});
		e = ev(w, ph, fb, cy, at, ro) == w[19];
		@(posedge clk);
		{insnValid, arm, lag, insnWord0, insnWord1, insnPc} <= {2'b11, v[2:0], w, v, pc};
		{busPhase, firstByteReceived, carryFlag, atnIn} <= {ph, fb, cy, at};
		do @(negedge clk); while (insnDone !== 1 && n++ < 30);
		chk(insnDone, 1);
		chk(fetchLoad, e && w[29:27] != 3);
		chk({irq, halted}, {e && mk, e} & {2{w[29:27] == 3}});
		if (e && w[29:27] == 1) begin
			chk(fetchAddr, w[23] ? pc + 8 + {{8{v[23]}}, v[23:0]} : v);
			retM = pc + 8;
		end
		if (e && w[29:27] == 2)
			chk(fetchAddr, retM);
		@(posedge clk);
		{insnValid, arm} <= 2'b00;
		apb(0, 8'h10, 0);
		chk(r, retM);
		if (e && w[29:27] == 3) begin
			apb(0, 8'h0C, 0);
			chk(r, v);
			apb(0, 8'h04, 0);
			chk(r[0], 1);
			apb(1, 8'h00, {30'h0, 2'b10 | ro});
			@(negedge clk);
			chk({irq, halted}, 0);
		end
	endtask
	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1;
		apb(0, 8'h1C, 0);
		chk(r, 0);
		chk(pslverr, 0);
		mk = 1;
		for (int i = 0; i < 3; i++)
			one(32'h080C_7F80, 32'h100, 32'h40, 0, fbs[i], 0, 0, 0);
		one(32'h1306_0055, 0, 32'h80, 3, 8'h55, 0, 0, 0);
		one(32'h1306_0055, 0, 32'h80, 2, 8'h55, 0, 0, 0);
		$display("corner cases done");
		repeat (60) begin
			lf = nx(lf);
			t = lf;
			lf = nx(lf);
			u = lf;
			w0 = {2'b0, 3'd1 + 3'(t[1:0] % 3), u[26:23], 1'b0, t[2] & t[3], 1'b0, u[19:0]};
			if (w0[21])
				w0[18:17] = 0;
			if ((w0[21:17] & 5'h13) == 0)
				w0[19] = 1;
			mk = t[9];
			one(w0, nx(u), {t[31:3], 3'h0}, t[5] ? w0[26:24] : t[18:16],
				t[4] ? w0[7:0] ^ (t[15:8] & w0[15:8]) : t[15:8], t[6], t[7], t[8]);
		end
		$display("random cases done");
		report_and_stop();
	end
endmodule
`default_nettype wire
